// *** inc/acl_pkg.sv ***
// constants and types shared by the ipv4 access control entry matcher
package acl_pkg;

	// ==========================================================
	// register port
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_PROTO    = 8'h04;
	localparam logic [7:0]  REG_SRC_ADDR = 8'h08;
	localparam logic [7:0]  REG_SRC_MASK = 8'h0c;
	localparam logic [7:0]  REG_DST_ADDR = 8'h10;
	localparam logic [7:0]  REG_DST_MASK = 8'h14;
	localparam logic [7:0]  REG_STATUS   = 8'h18;
	localparam logic [7:0]  REG_FRAMES   = 8'h1c;
	localparam logic [7:0]  REG_HITS     = 8'h20;

	// ==========================================================
	// control word layout
	localparam int CTRL_TYPE_LSB  = 0;
	localparam int CTRL_PROTO_LSB = 3;
	localparam int CTRL_TTL_LSB   = 6;
	localparam int CTRL_FRAG_LSB  = 8;
	localparam int CTRL_OPT_LSB   = 10;
	localparam int CTRL_SRC_LSB   = 12;
	localparam int CTRL_DST_LSB   = 14;

	// ==========================================================
	// status word layout and miss vector bits
	localparam int STAT_HIT_BIT  = 0;
	localparam int STAT_SEEN_BIT = 1;
	localparam int STAT_MISS_LSB = 8;
	localparam int MISS_W        = 8;
	localparam int MISS_TYPE     = 0;
	localparam int MISS_PROTO    = 1;
	localparam int MISS_TTL      = 2;
	localparam int MISS_FRAG     = 3;
	localparam int MISS_OPT      = 4;
	localparam int MISS_SRC      = 5;
	localparam int MISS_DST      = 6;
	localparam int MISS_SUB      = 7;

	// ==========================================================
	// header fields and fixed values
	localparam int          FRAG_OFF_W  = 13;
	localparam logic [7:0]  PROTO_ICMP  = 8'h01;
	localparam logic [7:0]  PROTO_TCP   = 8'h06;
	localparam logic [7:0]  PROTO_UDP   = 8'h11;
	localparam logic [7:0]  TTL_ZERO    = 8'h00;
	localparam logic [7:0]  PROTO_RESET = 8'h00;
	localparam logic [31:0] ADDR_RESET  = 32'h00000000;
	localparam logic [31:0] MASK_RESET  = 32'hffffffff;
	localparam logic [31:0] CNT_STEP    = 32'h00000001;

	// ==========================================================
	// modes
	typedef enum logic [2:0] {
		FT_ANY  = 3'b000,
		FT_ETH  = 3'b001,
		FT_ARP  = 3'b010,
		FT_IPV4 = 3'b011,
		FT_IPV6 = 3'b100
	} frame_type_t;

	typedef enum logic [2:0] {
		PM_ANY      = 3'b000,
		PM_SPECIFIC = 3'b001,
		PM_ICMP     = 3'b010,
		PM_UDP      = 3'b011,
		PM_TCP      = 3'b100
	} proto_mode_t;

	typedef enum logic [1:0] {
		TTL_ANY     = 2'b00,
		TTL_IS_ZERO = 2'b01,
		TTL_NONZERO = 2'b10
	} ttl_mode_t;

	typedef enum logic [1:0] {
		FLAG_ANY = 2'b00,
		FLAG_NO  = 2'b01,
		FLAG_YES = 2'b10
	} flag_mode_t;

	typedef enum logic [1:0] {
		AM_ANY     = 2'b00,
		AM_HOST    = 2'b01,
		AM_NETWORK = 2'b10
	} addr_mode_t;

endpackage : acl_pkg

// *** rtl/ip_addr_match.sv ***
// one address criterion: any, exact host, or masked network compare
`timescale 1ns/1ps
module ip_addr_match (
	// criterion
	input  acl_pkg::addr_mode_t mode,
	input  logic [31:0]         cfg_addr,
	input  logic [31:0]         cfg_mask,
	// frame
	input  logic [31:0]         frame_addr,
	// result
	output logic                match
);

	always_comb begin
		unique case (mode)
			acl_pkg::AM_ANY:     match = 1'b1;
			acl_pkg::AM_HOST:    match = (frame_addr == cfg_addr);
			// mask one compares, zero ignores
			acl_pkg::AM_NETWORK: match = ((frame_addr ^ cfg_addr) & cfg_mask) == '0;
			// unused code never matches, so a bad write cannot open the entry
			default:             match = 1'b0;
		endcase
	end

endmodule : ip_addr_match

// *** rtl/ipv4_acl_entry_matcher.sv ***
// ipv4 criteria matcher for one access control entry, with its register port
//
// Contract
// R1 - ipv4 criteria apply only when the entry frame type is ipv4
// R2 - protocol any ignores the protocol field
// R3 - protocol specific needs the field equal to the configured byte
// R4 - protocol icmp matches icmp frames, plus icmp sub-criteria
// R5 - protocol udp matches udp frames, plus udp port sub-criteria
// R6 - protocol tcp matches tcp frames, plus tcp sub-criteria
// R7 - ttl zero rejects ttl above zero; ttl any ignores it
// R8 - ttl non-zero allows only ttl above zero
// R9 - fragment no rejects fragments; fragment any ignores them
// R10 - fragment yes allows only frames with more-fragments or nonzero offset
// R11 - options no rejects frames with options; options any ignores them
// R12 - options yes allows only frames carrying options
// R13 - source any ignores the source address
// R14 - source host needs an exact source address match
// R15 - source network compares only bits selected by the source mask
// R16 - destination any ignores the destination address
// R17 - destination host needs an exact destination address match
// R18 - destination network compares only bits selected by the destination mask
// R19 - hit only when all enabled criteria match; mask one compares a bit
// R20 - parser presents all header fields with a valid strobe
`timescale 1ns/1ps
module ipv4_acl_entry_matcher (
	// clock and reset
	input  logic        clock,
	input  logic        rst_n,
	// register port
	input  logic [7:0]  reg_addr,
	input  logic [31:0] reg_wdata,
	input  logic        reg_wr,
	input  logic        reg_rd,
	output logic [31:0] reg_rdata,
	// parsed header from the frame parser
	input  logic        hdr_valid,
	input  logic        hdr_is_ipv4,
	input  logic [7:0]  hdr_protocol,
	input  logic [7:0]  hdr_ttl,
	input  logic        hdr_more_frag,
	input  logic [12:0] hdr_frag_offset,
	input  logic        hdr_has_options,
	input  logic [31:0] hdr_src_addr,
	input  logic [31:0] hdr_dst_addr,
	// icmp or tcp/udp sub-criteria result from the sibling matcher
	input  logic        sub_match,
	// result to the action logic
	output logic        hit_valid,
	output logic        hit
);

	// ==========================================================
	// state
	typedef struct packed {
		acl_pkg::frame_type_t ftype;
		acl_pkg::proto_mode_t pmode;
		acl_pkg::ttl_mode_t   ttl_mode;
		acl_pkg::flag_mode_t  frag_mode;
		acl_pkg::flag_mode_t  opt_mode;
		acl_pkg::addr_mode_t  src_mode;
		acl_pkg::addr_mode_t  dst_mode;
		logic [7:0]           proto;
		logic [31:0]          src_addr;
		logic [31:0]          src_mask;
		logic [31:0]          dst_addr;
		logic [31:0]          dst_mask;
		logic                 hit;
		logic                 hit_valid;
		logic                 last_hit;
		logic                 seen;
		logic [7:0]           miss;
		logic [31:0]          frame_cnt;
		logic [31:0]          hit_cnt;
		logic [31:0]          rdata;
	} state_t;

	// masks reset to all ones, so network mode starts as an exact compare
	localparam state_t STATE_RESET = '{
		ftype:     acl_pkg::FT_ANY,
		pmode:     acl_pkg::PM_ANY,
		ttl_mode:  acl_pkg::TTL_ANY,
		frag_mode: acl_pkg::FLAG_ANY,
		opt_mode:  acl_pkg::FLAG_ANY,
		src_mode:  acl_pkg::AM_ANY,
		dst_mode:  acl_pkg::AM_ANY,
		proto:     acl_pkg::PROTO_RESET,
		src_addr:  acl_pkg::ADDR_RESET,
		src_mask:  acl_pkg::MASK_RESET,
		dst_addr:  acl_pkg::ADDR_RESET,
		dst_mask:  acl_pkg::MASK_RESET,
		hit:       1'b0,
		hit_valid: 1'b0,
		last_hit:  1'b0,
		seen:      1'b0,
		miss:      '0,
		frame_cnt: '0,
		hit_cnt:   '0,
		rdata:     '0
	};

	state_t s_q;
	state_t s_d;

	// ==========================================================
	// per-criterion checks on the header as presented
	logic        ipv4_entry;
	logic        type_ok;
	logic        proto_ok;
	logic        sub_ok;
	logic        ttl_ok;
	logic        frag_ok;
	logic        opt_ok;
	logic        src_ok;
	logic        dst_ok;
	logic        is_fragment;
	logic        all_ok;
	logic        hit_now;
	logic [7:0]  miss_now;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	// a non-ipv4 entry leaves this stage transparent
	assign ipv4_entry = (s_q.ftype == acl_pkg::FT_IPV4); // R1
	// frames of other types never hit an ipv4 entry
	assign type_ok    = hdr_is_ipv4; // R1

	always_comb begin
		// the sibling result only counts for the three named protocols
		sub_ok = 1'b1;
		unique case (s_q.pmode)
			acl_pkg::PM_ANY: begin
				proto_ok = 1'b1; // R2
			end
			acl_pkg::PM_SPECIFIC: begin
				proto_ok = (hdr_protocol == s_q.proto); // R3
			end
			acl_pkg::PM_ICMP: begin
				proto_ok = (hdr_protocol == acl_pkg::PROTO_ICMP); // R4
				sub_ok   = sub_match; // R4
			end
			acl_pkg::PM_UDP: begin
				proto_ok = (hdr_protocol == acl_pkg::PROTO_UDP); // R5
				sub_ok   = sub_match; // R5
			end
			acl_pkg::PM_TCP: begin
				proto_ok = (hdr_protocol == acl_pkg::PROTO_TCP); // R6
				sub_ok   = sub_match; // R6
			end
			// codes five to seven are unused and block the entry
			default: begin
				proto_ok = 1'b0;
			end
		endcase
	end

	// code three is unused and never matches, as in every two-bit criterion
	always_comb begin
		unique case (s_q.ttl_mode)
			acl_pkg::TTL_ANY:     ttl_ok = 1'b1; // R7
			acl_pkg::TTL_IS_ZERO: ttl_ok = (hdr_ttl == acl_pkg::TTL_ZERO); // R7
			acl_pkg::TTL_NONZERO: ttl_ok = (hdr_ttl != acl_pkg::TTL_ZERO); // R8
			default:              ttl_ok = 1'b0;
		endcase
	end

	// the first piece carries the flag, later pieces an offset
	assign is_fragment = hdr_more_frag | (hdr_frag_offset != '0);

	always_comb begin
		unique case (s_q.frag_mode)
			acl_pkg::FLAG_ANY: frag_ok = 1'b1; // R9
			acl_pkg::FLAG_NO:  frag_ok = ~is_fragment; // R9
			acl_pkg::FLAG_YES: frag_ok = is_fragment; // R10
			default:           frag_ok = 1'b0;
		endcase
	end

	always_comb begin
		unique case (s_q.opt_mode)
			acl_pkg::FLAG_ANY: opt_ok = 1'b1; // R11
			acl_pkg::FLAG_NO:  opt_ok = ~hdr_has_options; // R11
			acl_pkg::FLAG_YES: opt_ok = hdr_has_options; // R12
			default:           opt_ok = 1'b0;
		endcase
	end

	// ==========================================================
	// address criteria, same logic for both directions
	ip_addr_match u_src_match ( // R13 R14 R15
		.mode       (s_q.src_mode),
		.cfg_addr   (s_q.src_addr),
		.cfg_mask   (s_q.src_mask),
		.frame_addr (hdr_src_addr),
		.match      (src_ok)
	);

	ip_addr_match u_dst_match ( // R16 R17 R18
		.mode       (s_q.dst_mode),
		.cfg_addr   (s_q.dst_addr),
		.cfg_mask   (s_q.dst_mask),
		.frame_addr (hdr_dst_addr),
		.match      (dst_ok)
	);

	// ==========================================================
	// combined decision
	assign all_ok  = type_ok & proto_ok & sub_ok & ttl_ok & frag_ok & opt_ok
		& src_ok & dst_ok; // R19
	assign hit_now = ~ipv4_entry | all_ok; // R1 R19

	// which criteria failed; kept for software debugging of the entry
	always_comb begin
		miss_now                      = '0;
		miss_now[acl_pkg::MISS_TYPE]  = ~type_ok;
		miss_now[acl_pkg::MISS_PROTO] = ~proto_ok;
		miss_now[acl_pkg::MISS_TTL]   = ~ttl_ok;
		miss_now[acl_pkg::MISS_FRAG]  = ~frag_ok;
		miss_now[acl_pkg::MISS_OPT]   = ~opt_ok;
		miss_now[acl_pkg::MISS_SRC]   = ~src_ok;
		miss_now[acl_pkg::MISS_DST]   = ~dst_ok;
		miss_now[acl_pkg::MISS_SUB]   = ~sub_ok;
		if (!ipv4_entry) begin
			miss_now = '0;
		end
	end

	// ==========================================================
	// register read views
	always_comb begin
		ctrl_word = '0;
		ctrl_word[acl_pkg::CTRL_TYPE_LSB  +: 3] = s_q.ftype;
		ctrl_word[acl_pkg::CTRL_PROTO_LSB +: 3] = s_q.pmode;
		ctrl_word[acl_pkg::CTRL_TTL_LSB   +: 2] = s_q.ttl_mode;
		ctrl_word[acl_pkg::CTRL_FRAG_LSB  +: 2] = s_q.frag_mode;
		ctrl_word[acl_pkg::CTRL_OPT_LSB   +: 2] = s_q.opt_mode;
		ctrl_word[acl_pkg::CTRL_SRC_LSB   +: 2] = s_q.src_mode;
		ctrl_word[acl_pkg::CTRL_DST_LSB   +: 2] = s_q.dst_mode;
	end

	always_comb begin
		status_word = '0;
		status_word[acl_pkg::STAT_HIT_BIT]                       = s_q.last_hit;
		status_word[acl_pkg::STAT_SEEN_BIT]                      = s_q.seen;
		status_word[acl_pkg::STAT_MISS_LSB +: acl_pkg::MISS_W]   = s_q.miss;
	end

	// unmapped addresses read as zero
	always_comb begin
		rd_word = '0;
		unique case (reg_addr)
			acl_pkg::REG_CTRL:     rd_word = ctrl_word;
			acl_pkg::REG_PROTO:    rd_word = {24'h000000, s_q.proto};
			acl_pkg::REG_SRC_ADDR: rd_word = s_q.src_addr;
			acl_pkg::REG_SRC_MASK: rd_word = s_q.src_mask;
			acl_pkg::REG_DST_ADDR: rd_word = s_q.dst_addr;
			acl_pkg::REG_DST_MASK: rd_word = s_q.dst_mask;
			acl_pkg::REG_STATUS:   rd_word = status_word;
			acl_pkg::REG_FRAMES:   rd_word = s_q.frame_cnt;
			acl_pkg::REG_HITS:     rd_word = s_q.hit_cnt;
			default:               rd_word = '0;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		s_d           = s_q;
		s_d.hit_valid = 1'b0;
		s_d.rdata     = '0;

		// configuration writes; a change applies from the next header on
		if (reg_wr) begin
			unique case (reg_addr)
				acl_pkg::REG_CTRL: begin
					s_d.ftype     = acl_pkg::frame_type_t'(
						reg_wdata[acl_pkg::CTRL_TYPE_LSB +: 3]);
					s_d.pmode     = acl_pkg::proto_mode_t'(
						reg_wdata[acl_pkg::CTRL_PROTO_LSB +: 3]);
					s_d.ttl_mode  = acl_pkg::ttl_mode_t'(
						reg_wdata[acl_pkg::CTRL_TTL_LSB +: 2]);
					s_d.frag_mode = acl_pkg::flag_mode_t'(
						reg_wdata[acl_pkg::CTRL_FRAG_LSB +: 2]);
					s_d.opt_mode  = acl_pkg::flag_mode_t'(
						reg_wdata[acl_pkg::CTRL_OPT_LSB +: 2]);
					s_d.src_mode  = acl_pkg::addr_mode_t'(
						reg_wdata[acl_pkg::CTRL_SRC_LSB +: 2]);
					s_d.dst_mode  = acl_pkg::addr_mode_t'(
						reg_wdata[acl_pkg::CTRL_DST_LSB +: 2]);
				end
				acl_pkg::REG_PROTO:    s_d.proto     = reg_wdata[7:0]; // R3
				acl_pkg::REG_SRC_ADDR: s_d.src_addr  = reg_wdata;
				acl_pkg::REG_SRC_MASK: s_d.src_mask  = reg_wdata;
				acl_pkg::REG_DST_ADDR: s_d.dst_addr  = reg_wdata;
				acl_pkg::REG_DST_MASK: s_d.dst_mask  = reg_wdata;
				// any write clears a counter
				acl_pkg::REG_FRAMES:   s_d.frame_cnt = '0;
				acl_pkg::REG_HITS:     s_d.hit_cnt   = '0;
				// status is read-only, so its address falls through here
				default: begin
				end
			endcase
		end

		// decision on each presented header; counting after the clear
		// means a frame in the clearing cycle is not lost
		if (hdr_valid) begin // R20
			s_d.hit_valid = 1'b1;
			s_d.hit       = hit_now;
			s_d.last_hit  = hit_now;
			s_d.seen      = 1'b1;
			s_d.miss      = miss_now;
			// both counters wrap at 32 bits; software reads deltas
			s_d.frame_cnt = s_d.frame_cnt + acl_pkg::CNT_STEP;
			if (hit_now) begin
				s_d.hit_cnt = s_d.hit_cnt + acl_pkg::CNT_STEP;
			end
		end

		// reads see the state before this cycle's updates
		if (reg_rd) begin
			s_d.rdata = rd_word;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign reg_rdata = s_q.rdata;
	assign hit_valid = s_q.hit_valid;
	assign hit       = s_q.hit;

endmodule : ipv4_acl_entry_matcher

// *** test/ipv4_acl_entry_matcher_asserts.sv ***
// port-level checks for the ipv4 access control entry matcher
`timescale 1ns/1ps
module ipv4_acl_entry_matcher_asserts (
	// clock and reset
	input logic        clock,
	input logic        rst_n,
	// register port
	input logic [7:0]  reg_addr,
	input logic [31:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [31:0] reg_rdata,
	// header and result
	input logic        hdr_valid,
	input logic        hdr_is_ipv4,
	input logic [7:0]  hdr_protocol,
	input logic [7:0]  hdr_ttl,
	input logic        hdr_more_frag,
	input logic [12:0] hdr_frag_offset,
	input logic        hdr_has_options,
	input logic        sub_match,
	input logic        hit_valid,
	input logic        hit
);
	// ==========
	// shadow of the criteria; a write in the header cycle lands after it
	logic [15:0] ctrl_q;
	logic [7:0]  proto_q;
	logic        v4;
	logic        frag;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q  <= 16'h0000;
			proto_q <= 8'h00;
		end else if (reg_wr && reg_addr == acl_pkg::REG_CTRL) begin
			ctrl_q <= reg_wdata[15:0];
		end else if (reg_wr && reg_addr == acl_pkg::REG_PROTO) begin
			proto_q <= reg_wdata[7:0];
		end
	end
	assign v4   = hdr_valid && ctrl_q[2:0] == 3'h3;
	assign frag = hdr_more_frag || hdr_frag_offset != 13'h0000;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// ==========
	// assertions
	a_result_timing: assert property (hdr_valid |=> hit_valid)
		else $error("hit_valid missing after header");
	a_hit_holds: assert property (!hdr_valid |=> !hit_valid && $stable(hit))
		else $error("result moved without a header");
	a_type_bypass: assert property (hdr_valid && ctrl_q[2:0] != 3'h3 |=> hit)
		else $error("non ipv4 entry did not pass");
	a_ipv4_only: assert property (v4 && !hdr_is_ipv4 |=> !hit)
		else $error("non ipv4 frame hit");
	a_proto_value: assert property (v4 && ctrl_q[5:3] == 3'h1 && hdr_protocol != proto_q
		|=> !hit)
		else $error("protocol value mismatch hit");
	a_sub_needed: assert property (v4 && ctrl_q[5:3] inside {3'h2, 3'h3, 3'h4} && !sub_match
		|=> !hit)
		else $error("hit without sub criteria");
	a_ttl_zero: assert property (v4 && ctrl_q[7:6] == 2'h1 && hdr_ttl != 8'h00 |=> !hit)
		else $error("ttl zero mode hit");
	a_ttl_nonzero: assert property (v4 && ctrl_q[7:6] == 2'h2 && hdr_ttl == 8'h00 |=> !hit)
		else $error("ttl nonzero mode hit");
	a_frag_no: assert property (v4 && ctrl_q[9:8] == 2'h1 && frag |=> !hit)
		else $error("fragment hit in no mode");
	a_frag_yes: assert property (v4 && ctrl_q[9:8] == 2'h2 && !frag |=> !hit)
		else $error("unfragmented hit in yes mode");
	a_opt_mode: assert property (v4 && (ctrl_q[11:10] == 2'h1 && hdr_has_options
		|| ctrl_q[11:10] == 2'h2 && !hdr_has_options) |=> !hit)
		else $error("options mode violated");
	c_ipv4_hit: cover property (v4 ##1 hit);
	c_ipv4_miss: cover property (v4 ##1 !hit);
	c_back_to_back: cover property (hdr_valid [*2]);
	c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : ipv4_acl_entry_matcher_asserts

// *** test/hdr_source.sv ***
// frame header parser model feeding the matcher
`timescale 1ns/1ps
module hdr_source (
	// clock and reset
	input  logic        clock,
	input  logic        rst_n,
	// bench request
	input  logic        en,
	// parsed header
	output logic        hdr_valid,
	output logic        hdr_is_ipv4,
	output logic [7:0]  hdr_protocol,
	output logic [7:0]  hdr_ttl,
	output logic        hdr_more_frag,
	output logic [12:0] hdr_frag_offset,
	output logic        hdr_has_options,
	output logic [31:0] hdr_src_addr,
	output logic [31:0] hdr_dst_addr,
	output logic        sub_match
);
	// ==========
	// values are biased so that every criterion both hits and misses
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hdr_valid <= 1'b0;
			{hdr_is_ipv4, hdr_protocol, hdr_ttl, hdr_more_frag, hdr_frag_offset} <= '0;
			{hdr_has_options, hdr_src_addr, hdr_dst_addr, sub_match} <= '0;
		end else if (en) begin
			hdr_valid       <= 1'b1;
			hdr_is_ipv4     <= ($urandom % 8) != 0;
			hdr_protocol    <= 8'(($urandom % 2) ? 17 : $urandom % 8);
			hdr_ttl         <= 8'($urandom % 3);
			hdr_more_frag   <= ($urandom % 4) == 0;
			hdr_frag_offset <= 13'($urandom % 2);
			hdr_has_options <= 1'($urandom);
			hdr_src_addr    <= 32'h0a000000 | 32'($urandom % 4);
			hdr_dst_addr    <= 32'hc0a80000 | 32'($urandom % 4);
			sub_match       <= ($urandom % 4) != 0;
		end else begin
			// stale fields are inverted so an early sample cannot match by luck
			hdr_valid <= 1'b0;
			{hdr_is_ipv4, hdr_protocol, hdr_ttl, hdr_more_frag, hdr_frag_offset} <=
				~{hdr_is_ipv4, hdr_protocol, hdr_ttl, hdr_more_frag, hdr_frag_offset};
			{hdr_has_options, hdr_src_addr, hdr_dst_addr, sub_match} <=
				~{hdr_has_options, hdr_src_addr, hdr_dst_addr, sub_match};
		end
	end
endmodule : hdr_source

// *** test/ipv4_acl_entry_matcher_tb.sv ***
// self-checking bench for the ipv4 access control entry matcher
`timescale 1ns/1ps
module ipv4_acl_entry_matcher_tb;
	// ==========
	// signals and bench state
	logic        clock, rst_n, reg_wr, reg_rd, hdr_valid, hdr_is_ipv4, hdr_more_frag;
	logic        hdr_has_options, sub_match, hit_valid, hit, en, rd_p;
	logic [7:0]  reg_addr, hdr_protocol, hdr_ttl, pv;
	logic [12:0] hdr_frag_offset;
	logic [15:0] ctrl, c;
	logic [31:0] reg_wdata, reg_rdata, hdr_src_addr, hdr_dst_addr, sa, sm, da, dm;
	logic [31:0] rd_q[$];
	logic        hit_q[$];
	int          errors, cmp_count, nframes, nhits;
	ipv4_acl_entry_matcher i_dut (.*);
	hdr_source i_src (.*);
	always #2.5 clock = ~clock;
	// ==========
	// reference decision
	function automatic logic fl(input logic [1:0] m, input logic v);
		return m == 2'h0 ? 1'b1 : m == 2'h1 ? !v : m == 2'h2 ? v : 1'b0;
	endfunction : fl
	function automatic logic am(input logic [1:0] m, input logic [31:0] a, cf, k);
		return m == 2'h0 ? 1'b1 : m == 2'h1 ? a == cf : m == 2'h2 ? ((a ^ cf) & k) == 0 : 1'b0;
	endfunction : am
	function automatic logic exp_hit();
		logic pr;
		case (ctrl[5:3])
			3'h0: pr = 1'b1;
			3'h1: pr = hdr_protocol == pv;
			3'h2: pr = hdr_protocol == acl_pkg::PROTO_ICMP && sub_match;
			3'h3: pr = hdr_protocol == acl_pkg::PROTO_UDP && sub_match;
			3'h4: pr = hdr_protocol == acl_pkg::PROTO_TCP && sub_match;
			default: pr = 1'b0;
		endcase
		if (ctrl[2:0] != 3'h3) return 1'b1;
		return hdr_is_ipv4 && pr && fl(ctrl[7:6], hdr_ttl != 8'h00)
			&& fl(ctrl[9:8], hdr_more_frag || hdr_frag_offset != 13'h0)
			&& fl(ctrl[11:10], hdr_has_options)
			&& am(ctrl[13:12], hdr_src_addr, sa, sm)
			&& am(ctrl[15:14], hdr_dst_addr, da, dm);
	endfunction : exp_hit
	// ==========
	// tasks
	task automatic check(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		reg_wr   <= 1'b0;
		@(posedge clock);
	endtask : rd
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask : idle
	task automatic final_report();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	// ==========
	// monitor: note expectations at the header, compare when results appear
	always @(posedge clock) begin
		if (rd_p) check("reg_rdata", reg_rdata, rd_q.pop_front());
		if (hit_valid) check("hit", {31'h0, hit}, {31'h0, hit_q.pop_front()});
		if (hdr_valid) begin
			hit_q.push_back(exp_hit());
			nhits += int'(exp_hit());
			nframes++;
		end
		if (reg_wr) begin
			case (reg_addr)
				acl_pkg::REG_CTRL: ctrl = reg_wdata[15:0];
				acl_pkg::REG_PROTO: pv = reg_wdata[7:0];
				acl_pkg::REG_SRC_ADDR: sa = reg_wdata;
				acl_pkg::REG_SRC_MASK: sm = reg_wdata;
				acl_pkg::REG_DST_ADDR: da = reg_wdata;
				acl_pkg::REG_DST_MASK: dm = reg_wdata;
				default: ;
			endcase
		end
		rd_p = reg_rd && rst_n;
	end
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		final_report();
	end
	// ==========
	// main sequence
	initial begin
		{clock, rst_n, reg_wr, reg_rd, en, rd_p, reg_addr, reg_wdata} = '0;
		{ctrl, pv, sa, da, sm, dm, c} = {16'h0, 8'h0, 64'h0, 64'hffffffffffffffff, 16'h0};
		void'($urandom(45038));
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rd(acl_pkg::REG_SRC_MASK, acl_pkg::MASK_RESET);
		rd(acl_pkg::REG_STATUS, 32'h0);
		rd(acl_pkg::REG_CTRL, 32'h0);
		rd(acl_pkg::REG_FRAMES, 32'h0);
		rd(8'h24, 32'h0);
		for (int i = 0; i < 45; i++) begin
			// options code three and protocol code five exercise the unused codes
			c = {2'((i / 5) % 3), 2'((i / 2) % 3), 2'((i / 9) % 4), 2'((i / 3) % 3),
				2'(i % 3), 3'(i % 6), (i % 7 == 6) ? 3'(i % 5) : 3'h3};
			wr(acl_pkg::REG_CTRL, {16'h0, c});
			wr(acl_pkg::REG_PROTO, 32'($urandom % 8));
			wr(acl_pkg::REG_SRC_ADDR, 32'h0a000000 | 32'($urandom % 4));
			wr(acl_pkg::REG_SRC_MASK, ($urandom % 2) ? 32'hffffffff : 32'hfffffffc);
			// header lands in the same cycle as the last write: old mask applies
			en <= 1'b1;
			wr(acl_pkg::REG_DST_ADDR, 32'hc0a80000 | 32'($urandom % 4));
			wr(acl_pkg::REG_DST_MASK, ($urandom % 2) ? 32'hffffffff : 32'hfffffffc);
			idle();
			repeat (20) @(posedge clock);
			en <= 1'b0;
			repeat (2) @(posedge clock);
		end
		rd(acl_pkg::REG_CTRL, {16'h0, c});
		rd(acl_pkg::REG_FRAMES, nframes);
		rd(acl_pkg::REG_HITS, nhits);
		// a transparent entry passes one header: status shows seen and hit
		wr(acl_pkg::REG_CTRL, 32'h0);
		en <= 1'b1;
		idle();
		en <= 1'b0;
		idle();
		rd(acl_pkg::REG_STATUS, 32'h3);
		wr(acl_pkg::REG_FRAMES, 32'h0);
		rd(acl_pkg::REG_FRAMES, 32'h0);
		idle();
		repeat (3) @(posedge clock);
		check("pending hits", 32'(hit_q.size()), 32'h0);
		final_report();
	end
endmodule : ipv4_acl_entry_matcher_tb
bind ipv4_acl_entry_matcher ipv4_acl_entry_matcher_asserts i_chk (.*);
